//--- svtm_pkg.sv
package svtm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Terminal counts and field widths
  localparam int unsigned IN_CNT = 8;
  localparam int unsigned OUT_CNT = 5;
  localparam int unsigned IN_CODE_W = 6;
  localparam int unsigned OUT_CODE_W = 5;
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned ALM_TERM = 4;
  localparam int unsigned RESTART_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] A_IN_SEL_LO = 8'h00;
  localparam logic [7:0] A_IN_SEL_HI = 8'h04;
  localparam logic [7:0] A_IN_POL = 8'h08;
  localparam logic [7:0] A_OUT_SEL = 8'h0C;
  localparam logic [7:0] A_ALM_SEL = 8'h10;
  localparam logic [7:0] A_RESTART = 8'h14;
  localparam logic [7:0] A_ROT_THR = 8'h18;
  localparam logic [7:0] A_IN_STAT = 8'h1C;
  localparam logic [7:0] A_OUT_STAT = 8'h20;
  localparam logic [7:0] A_ACT_STAT = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [31:0] RST_IN_SEL_LO = 32'h0D0C_0A01;
  localparam logic [31:0] RST_IN_SEL_HI = 32'h1B1A_160E;
  localparam logic [7:0] RST_IN_POL = 8'h00;
  localparam logic [31:0] RST_OUT_SEL = 32'h0302_0100;
  localparam logic [4:0] RST_ALM_SEL = 5'h06;
  localparam logic [15:0] RST_ROT_THR = 16'h0014;

  ////////////////////////////////////////////////////////////////////////////
  // Input function codes
  localparam logic [5:0] FI_FAULT_CLR = 6'h01;
  localparam logic [5:0] FI_GAIN = 6'h08;
  localparam logic [5:0] FI_DEV_ZERO = 6'h0A;
  localparam logic [5:0] FI_PULSE_BLK = 6'h0B;
  localparam logic [5:0] FI_EHALT = 6'h0C;
  localparam logic [5:0] FI_REV_BLK = 6'h0D;
  localparam logic [5:0] FI_FWD_BLK = 6'h0E;
  localparam logic [5:0] FI_ORIGIN = 6'h16;
  localparam logic [5:0] FI_JOG_FWD = 6'h1A;
  localparam logic [5:0] FI_JOG_REV = 6'h1B;
  localparam logic [5:0] FI_OVERTEMP = 6'h1C;
  localparam logic [5:0] FI_PROBE1 = 6'h22;
  localparam logic [5:0] FI_PROBE2 = 6'h23;

  ////////////////////////////////////////////////////////////////////////////
  // Output function codes
  localparam logic [4:0] FO_READY = 5'h00;
  localparam logic [4:0] FO_ENERGISED = 5'h01;
  localparam logic [4:0] FO_ROT_DET = 5'h02;
  localparam logic [4:0] FO_SPD_REACHED = 5'h03;
  localparam logic [4:0] FO_POS_DONE = 5'h04;
  localparam logic [4:0] FO_TRQ_LIM = 5'h05;
  localparam logic [4:0] FO_FAULT = 5'h06;
  localparam logic [4:0] FO_BRAKE = 5'h07;
  localparam logic [4:0] FO_OL_WARN = 5'h08;
  localparam logic [4:0] FO_SPD_LIM = 5'h09;
  localparam logic [4:0] FO_DEV_WARN = 5'h0B;
  localparam logic [4:0] FO_HOME_DONE = 5'h0C;
  localparam logic [4:0] FO_DYN_BRAKE = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic ready;
    logic energised;
    logic signed [15:0] speed;
    logic speed_reached;
    logic position_done;
    logic torque_limited;
    logic fault;
    logic brake;
    logic overload_warn;
    logic speed_limited;
    logic deviation_warn;
    logic home_done;
    logic dyn_brake;
    logic pos_mode;
  } svtm_stat_t;

  typedef struct packed {
    logic fault_clear;
    logic gain_alt;
    logic deviation_zero;
    logic pulse_block;
    logic emergency_halt;
    logic reverse_block;
    logic forward_block;
    logic homing_origin;
    logic jog_forward;
    logic jog_reverse;
    logic motor_overtemp;
    logic probe1;
    logic probe2;
  } svtm_act_t;

endpackage

//--- svtm_top.sv
`timescale 1ns/1ps
// Behaviour
// - Eight input terminals, each with function select
// - Per input normally-open or normally-closed sense
// - Assignments take effect only at restart
// - Code 1 edge clears faults and alarms
// - Code 8 level selects alternate gain
// - Code 10 edge zeroes deviation, position mode
// - Code 11 level blocks pulse commands, position
// - Codes 12-14 halt, block reverse, forward
// - Code 22 edge is homing origin
// - Codes 26-28 jog forward, reverse, overheat
// - Four outputs plus alarm output, each selectable
// - Output code 0 ready with faults cleared
// - Output code 1 while motor energised
// - Output code 2 when speed above threshold
// - Output code 3 when speed reached
// - Codes 4,5 position done, torque limited
// - Output code 6 on detected fault
// - Codes 7,8 brake actuation, overload warning
// - Codes 9,11 speed limited, deviation excessive
// - Output code 12 homing completed
// - Output code 16 dynamic braking active
module svtm_top
  import svtm_pkg::*;
#(
  parameter int unsigned N_IN = IN_CNT,
  parameter int unsigned N_OUT = OUT_CNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [N_IN-1:0] di_pins,
  input wire svtm_stat_t drive_stat,
  output svtm_act_t drive_act,
  output logic [N_OUT-1:0] do_pins
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (N_IN < 1 || N_IN > IN_CNT) begin : g_bad_in
    $error("svtm_top: N_IN out of range");
  end
  if (N_OUT < 1 || N_OUT > OUT_CNT) begin : g_bad_out
    $error("svtm_top: N_OUT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [IN_CNT-1:0][IN_CODE_W-1:0] sh_in_sel_q;
  logic [IN_CNT-1:0][IN_CODE_W-1:0] in_sel_q;
  logic [IN_CNT-1:0] sh_pol_q;
  logic [IN_CNT-1:0] pol_q;
  logic [OUT_CNT-1:0][OUT_CODE_W-1:0] sh_out_sel_q;
  logic [OUT_CNT-1:0][OUT_CODE_W-1:0] out_sel_q;
  logic [15:0] rot_thr_q;
  logic load_q;
  logic dp_wr_q;
  logic rd_pend_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  logic aphase;
  logic [IN_CNT-1:0] pins_ext;
  logic [IN_CNT-1:0] cor;
  logic [IN_CNT-1:0] prev_q;
  logic [IN_CNT-1:0] rise;
  logic [16:0] speed_abs;
  logic rot_det;
  svtm_act_t act_q;
  logic [OUT_CNT-1:0] do_q;

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign drive_act = act_q;
  assign do_pins = do_q[N_OUT-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic hit(input logic [IN_CNT-1:0] v,
                               input logic [IN_CNT-1:0][IN_CODE_W-1:0] s,
                               input logic [IN_CODE_W-1:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < IN_CNT; i++) begin
      r = r | (v[i] & (s[i] == code));
    end
    return r;
  endfunction

  function automatic logic status_of(input logic [OUT_CODE_W-1:0] code,
                                     input svtm_stat_t st,
                                     input logic rot);
    logic r;
    r = 1'b0;
    case (code)
      FO_READY: r = st.ready & ~st.fault;
      FO_ENERGISED: r = st.energised;
      FO_ROT_DET: r = rot;
      FO_SPD_REACHED: r = st.speed_reached;
      FO_POS_DONE: r = st.position_done;
      FO_TRQ_LIM: r = st.torque_limited;
      FO_FAULT: r = st.fault;
      FO_BRAKE: r = st.brake;
      FO_OL_WARN: r = st.overload_warn;
      FO_SPD_LIM: r = st.speed_limited;
      FO_DEV_WARN: r = st.deviation_warn;
      FO_HOME_DONE: r = st.home_done;
      FO_DYN_BRAKE: r = st.dyn_brake;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave handshake
  assign aphase = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      dp_wr_q <= aphase & hwrite;
      rd_pend_q <= aphase & ~hwrite;
      hready_q <= ~(aphase & ~hwrite);
      hresp_q <= 1'b0;
      if (aphase) begin
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= 32'h0000_0000;
      unique case (dp_addr_q)
        A_IN_SEL_LO: begin
          for (int i = 0; i < 4; i++) begin
            hrdata_q[i*FIELD_W +: IN_CODE_W] <= sh_in_sel_q[i];
          end
        end
        A_IN_SEL_HI: begin
          for (int i = 0; i < 4; i++) begin
            hrdata_q[i*FIELD_W +: IN_CODE_W] <= sh_in_sel_q[i+4];
          end
        end
        A_IN_POL: hrdata_q[IN_CNT-1:0] <= sh_pol_q;
        A_OUT_SEL: begin
          for (int i = 0; i < 4; i++) begin
            hrdata_q[i*FIELD_W +: OUT_CODE_W] <= sh_out_sel_q[i];
          end
        end
        A_ALM_SEL: hrdata_q[OUT_CODE_W-1:0] <= sh_out_sel_q[ALM_TERM];
        A_ROT_THR: hrdata_q[15:0] <= rot_thr_q;
        A_IN_STAT: hrdata_q[15:0] <= {cor, pins_ext};
        A_OUT_STAT: hrdata_q[OUT_CNT-1:0] <= do_q;
        A_ACT_STAT: hrdata_q[$bits(svtm_act_t)-1:0] <= act_q;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow settings written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        sh_in_sel_q[i] <= RST_IN_SEL_LO[i*FIELD_W +: IN_CODE_W];
        sh_in_sel_q[i+4] <= RST_IN_SEL_HI[i*FIELD_W +: IN_CODE_W];
        sh_out_sel_q[i] <= RST_OUT_SEL[i*FIELD_W +: OUT_CODE_W];
      end
      sh_out_sel_q[ALM_TERM] <= RST_ALM_SEL;
      sh_pol_q <= RST_IN_POL;
      rot_thr_q <= RST_ROT_THR;
    end else if (dp_wr_q) begin
      unique case (dp_addr_q)
        A_IN_SEL_LO: begin
          for (int i = 0; i < 4; i++) begin
            sh_in_sel_q[i] <= hwdata[i*FIELD_W +: IN_CODE_W];
          end
        end
        A_IN_SEL_HI: begin
          for (int i = 0; i < 4; i++) begin
            sh_in_sel_q[i+4] <= hwdata[i*FIELD_W +: IN_CODE_W];
          end
        end
        A_IN_POL: sh_pol_q <= hwdata[IN_CNT-1:0];
        A_OUT_SEL: begin
          for (int i = 0; i < 4; i++) begin
            sh_out_sel_q[i] <= hwdata[i*FIELD_W +: OUT_CODE_W];
          end
        end
        A_ALM_SEL: sh_out_sel_q[ALM_TERM] <= hwdata[OUT_CODE_W-1:0];
        A_ROT_THR: rot_thr_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup latch of terminal assignments
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_q <= 1'b1;
    end else begin
      load_q <= dp_wr_q & (dp_addr_q == A_RESTART) &
                hwdata[RESTART_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        in_sel_q[i] <= RST_IN_SEL_LO[i*FIELD_W +: IN_CODE_W];
        in_sel_q[i+4] <= RST_IN_SEL_HI[i*FIELD_W +: IN_CODE_W];
        out_sel_q[i] <= RST_OUT_SEL[i*FIELD_W +: OUT_CODE_W];
      end
      out_sel_q[ALM_TERM] <= RST_ALM_SEL;
      pol_q <= RST_IN_POL;
    end else if (load_q) begin
      in_sel_q <= sh_in_sel_q;
      out_sel_q <= sh_out_sel_q;
      pol_q <= sh_pol_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input terminals
  always_comb begin
    pins_ext = '0;
    pins_ext[N_IN-1:0] = di_pins;
  end

  assign cor = pins_ext ^ pol_q;
  assign rise = cor & ~prev_q & {IN_CNT{~load_q}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= cor;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= '0;
    end else begin
      act_q.fault_clear <= hit(rise, in_sel_q, FI_FAULT_CLR);
      act_q.gain_alt <= hit(cor, in_sel_q, FI_GAIN);
      act_q.deviation_zero <= drive_stat.pos_mode &
                              hit(rise, in_sel_q, FI_DEV_ZERO);
      act_q.pulse_block <= drive_stat.pos_mode &
                           hit(cor, in_sel_q, FI_PULSE_BLK);
      act_q.emergency_halt <= hit(cor, in_sel_q, FI_EHALT);
      act_q.reverse_block <= hit(cor, in_sel_q, FI_REV_BLK);
      act_q.forward_block <= hit(cor, in_sel_q, FI_FWD_BLK);
      act_q.homing_origin <= hit(rise, in_sel_q, FI_ORIGIN);
      act_q.jog_forward <= hit(cor, in_sel_q, FI_JOG_FWD);
      act_q.jog_reverse <= hit(cor, in_sel_q, FI_JOG_REV);
      act_q.motor_overtemp <= hit(cor, in_sel_q, FI_OVERTEMP);
      act_q.probe1 <= hit(cor, in_sel_q, FI_PROBE1);
      act_q.probe2 <= hit(cor, in_sel_q, FI_PROBE2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output terminals
  assign speed_abs = drive_stat.speed[15] ?
                     17'(-$signed({drive_stat.speed[15], drive_stat.speed})) :
                     {1'b0, drive_stat.speed};
  assign rot_det = speed_abs > {1'b0, rot_thr_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      do_q <= '0;
    end else begin
      for (int j = 0; j < OUT_CNT; j++) begin
        do_q[j] <= status_of(out_sel_q[j], drive_stat, rot_det);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_restart_wr;
    dp_wr_q && dp_addr_q == A_RESTART && hwdata[RESTART_BIT];
  endsequence

  sequence s_latched;
    load_q ##1 (in_sel_q == $past(sh_in_sel_q) &&
                out_sel_q == $past(sh_out_sel_q));
  endsequence

  property p_restart;
    s_restart_wr |=> s_latched;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not latch settings");

  property p_cfg_hold;
    !load_q |=> $stable(in_sel_q) && $stable(out_sel_q) && $stable(pol_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("assignment changed without restart");

  property p_fault_clear;
    act_q.fault_clear |-> ($past(rise) != '0) ##1 !act_q.fault_clear;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault clear pulse wrong");

  property p_gain;
    hit(cor, in_sel_q, FI_GAIN)[*2] |=> act_q.gain_alt;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain select not following input");

  property p_dev_zero;
    act_q.deviation_zero |-> $past(drive_stat.pos_mode);
  endproperty
  a_dev_zero: assert property (p_dev_zero)
    else $error("deviation zero outside position mode");

  property p_pulse_block;
    drive_stat.pos_mode && hit(cor, in_sel_q, FI_PULSE_BLK)
      |=> act_q.pulse_block;
  endproperty
  a_pulse_block: assert property (p_pulse_block)
    else $error("pulse block missing");

  property p_ehalt;
    !hit(cor, in_sel_q, FI_EHALT) |=> !act_q.emergency_halt;
  endproperty
  a_ehalt: assert property (p_ehalt)
    else $error("halt active without input");

  property p_origin;
    hit(rise, in_sel_q, FI_ORIGIN) |=> act_q.homing_origin;
  endproperty
  a_origin: assert property (p_origin)
    else $error("origin edge lost");

  property p_rot;
    out_sel_q[2] == FO_ROT_DET && rot_det |=> do_q[2];
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotation detect output missing");

  property p_ready;
    out_sel_q[0] == FO_READY && drive_stat.fault |=> !do_q[0];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready shown during fault");

  property p_reserved;
    out_sel_q[3] == 5'h0A |=> !do_q[3];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved output code drove output");

endmodule

//--- svtm_field_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Switches on the eight input terminals and a brake on one output
module svtm_field_model (
  input wire logic [7:0] press,
  input wire logic [7:0] nc_mask,
  input wire logic [4:0] do_pins,
  output logic [7:0] di_pins,
  output logic brake_held
);
  // Normally closed contact opens when pressed
  assign di_pins = press ^ nc_mask;
  // Brake holds the shaft while its terminal is inactive
  assign brake_held = ~do_pins[2];
endmodule

//--- servo_terminal_function_map_bench.sv
`timescale 1ns/1ps
module servo_terminal_function_map_bench;
  import svtm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] di_pins;
  svtm_stat_t drive_stat = '0;
  svtm_act_t drive_act;
  logic [4:0] do_pins;
  logic [7:0] press = 8'h0;
  logic [7:0] nc_mask = 8'h0;
  logic brake_held;
  int num_errors = 0;
  int samples_checked = 0;

  always #5 hclk = ~hclk;

  svtm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .di_pins(di_pins),
    .drive_stat(drive_stat), .drive_act(drive_act), .do_pins(do_pins));

  svtm_field_model far (.press(press), .nc_mask(nc_mask),
    .do_pins(do_pins), .di_pins(di_pins), .brake_held(brake_held));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus wait too long", $time);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic restart();
    wr(A_RESTART, 32'h1);
    tick(3);
  endtask

  function automatic svtm_stat_t stf(input logic r, input logic e,
      input logic [15:0] s, input logic [10:0] f);
    return svtm_stat_t'({r, e, s, f});
  endfunction

  task automatic act_lvl(input int k, input logic [12:0] e);
    @(posedge hclk);
    press[k] <= 1'b1;
    tick(2);
    #1;
    chk({19'h0, drive_act}, {19'h0, e});
    @(posedge hclk);
    press[k] <= 1'b0;
    tick(2);
    #1;
    chk({19'h0, drive_act}, 32'h0);
  endtask

  task automatic act_edge(input int k, input logic [12:0] e);
    @(posedge hclk);
    press[k] <= 1'b1;
    @(posedge hclk);
    #1;
    chk({19'h0, drive_act}, {19'h0, e});
    tick(1);
    #1;
    chk({19'h0, drive_act}, 32'h0);
    tick(3);
    #1;
    chk({19'h0, drive_act}, 32'h0);
    @(posedge hclk);
    press[k] <= 1'b0;
    tick(2);
    #1;
    chk({19'h0, drive_act}, 32'h0);
  endtask

  task automatic out_chk(input svtm_stat_t s, input logic [4:0] e);
    @(posedge hclk);
    drive_stat <= s;
    tick(2);
    #1;
    chk({27'h0, do_pins}, {27'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic regs_after_reset();
    rd_chk(A_IN_SEL_LO, RST_IN_SEL_LO);
    rd_chk(A_IN_SEL_HI, RST_IN_SEL_HI);
    rd_chk(A_IN_POL, 32'h0);
    rd_chk(A_OUT_SEL, RST_OUT_SEL);
    rd_chk(A_ALM_SEL, {27'h0, RST_ALM_SEL});
    rd_chk(A_ROT_THR, {16'h0, RST_ROT_THR});
    rd_chk(A_RESTART, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic default_inputs();
    act_edge(0, 13'h1000);
    act_edge(1, 13'h0000);
    @(posedge hclk);
    drive_stat <= stf(1'b0, 1'b0, 16'h0, 11'h001);
    act_edge(1, 13'h0400);
    act_lvl(2, 13'h0100);
    act_lvl(3, 13'h0080);
    act_lvl(4, 13'h0040);
    act_edge(5, 13'h0020);
    act_lvl(6, 13'h0010);
    act_lvl(7, 13'h0008);
  endtask

  task automatic remapped_inputs();
    wr(A_IN_SEL_LO, 32'h001C_0B08);
    wr(A_IN_SEL_HI, 32'h0901_2322);
    wr(A_IN_POL, 32'h0000_0002);
    act_edge(0, 13'h1000);
    @(posedge hclk);
    nc_mask <= 8'h02;
    restart();
    tick(3);
    rd_chk(A_IN_POL, 32'h2);
    rd_chk(A_IN_STAT, 32'h0000_0002);
    act_lvl(0, 13'h0800);
    act_lvl(1, 13'h0200);
    act_lvl(2, 13'h0004);
    act_lvl(3, 13'h0000);
    act_lvl(4, 13'h0002);
    act_lvl(5, 13'h0001);
    act_edge(6, 13'h1000);
    act_lvl(7, 13'h0000);
    @(posedge hclk);
    press[2] <= 1'b1;
    rd_chk(A_ACT_STAT, 32'h0000_0004);
    rd_chk(A_IN_STAT, 32'h0000_0406);
    @(posedge hclk);
    press[2] <= 1'b0;
    tick(2);
  endtask

  task automatic outputs();
    out_chk(stf(1'b1, 1'b0, 16'h0, 11'h000), 5'h01);
    out_chk(stf(1'b1, 1'b0, 16'h0, 11'h080), 5'h10);
    out_chk(stf(1'b0, 1'b1, 16'h0, 11'h000), 5'h02);
    out_chk(stf(1'b0, 1'b0, 16'd20, 11'h000), 5'h00);
    out_chk(stf(1'b0, 1'b0, 16'd21, 11'h000), 5'h04);
    out_chk(stf(1'b0, 1'b0, -16'sd21, 11'h000), 5'h04);
    wr(A_ROT_THR, 32'h0000_0030);
    out_chk(stf(1'b0, 1'b0, 16'h0030, 11'h000), 5'h00);
    out_chk(stf(1'b0, 1'b0, 16'h0031, 11'h000), 5'h04);
    rd_chk(A_OUT_STAT, 32'h0000_0004);
    rd_chk(A_ROT_THR, 32'h0000_0030);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h400), 5'h08);
    wr(A_OUT_SEL, 32'h0807_0504);
    wr(A_ALM_SEL, 32'h0000_0009);
    out_chk(stf(1'b0, 1'b1, 16'h0, 11'h000), 5'h02);
    restart();
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h200), 5'h01);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h100), 5'h02);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h040), 5'h04);
    chk({31'h0, brake_held}, 32'h0);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h020), 5'h08);
    chk({31'h0, brake_held}, 32'h1);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h010), 5'h10);
    wr(A_OUT_SEL, 32'h0A10_0C0B);
    wr(A_ALM_SEL, 32'h0000_000D);
    restart();
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h008), 5'h01);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h004), 5'h02);
    out_chk(stf(1'b0, 1'b0, 16'h0, 11'h002), 5'h04);
    out_chk(stf(1'b1, 1'b1, 16'h7FFF, 11'h7FF), 5'h07);
  endtask

  task automatic reset_again();
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(2);
    #1;
    chk({27'h0, do_pins}, 32'h0);
    chk({19'h0, drive_act}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(A_ALM_SEL, {27'h0, RST_ALM_SEL});
    rd_chk(A_ROT_THR, {16'h0, RST_ROT_THR});
    out_chk(stf(1'b1, 1'b0, 16'h0, 11'h080), 5'h10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    tick(3);
    hresetn <= 1'b1;
    regs_after_reset();
    default_inputs();
    remapped_inputs();
    outputs();
    reset_again();
    summarize();
  end

  initial begin
    tick(20000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule
